// file: fast_counter_pkg.sv
// Functional notes
// - set-compare match drives output on immediately
// - set/clear compare only on count steps, never otherwise
// - set-compare match may raise vector interrupt
// - inhibit flag suppresses all counter interrupts
// - clear-compare match clears output immediately
// - clear-compare on counter resets that counter
// - zone outputs one-hot: below, inside, above
// - zone outputs evaluated when compare enabled
// - density meter counts edges per window
// - frequency limited per 16 or 32 bit form
// - pulse count zero means endless pulses
// - frequency change applies while running
// - pulse count latched only at enable
// - disable stops generator, output low
// - half duty, timing independent of scan
// - done flag set after programmed pulses
// - two independent generators, two outputs
package fast_counter_pkg;
	localparam int CNT_W = 32;
	localparam int WIN_W = 16;
	localparam int VEC_W = 3;
	localparam int ZONE_N = 3;
	localparam int ZONE_BELOW = 0;
	localparam int ZONE_INSIDE = 1;
	localparam int ZONE_ABOVE = 2;
	localparam logic [VEC_W-1:0] VEC_FIRST = 3'h1;
	localparam logic [VEC_W-1:0] VEC_LAST = 3'h6;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CLK_HZ = 40000000;
	localparam int WINDOW_UNIT_NS = 1000000;
	localparam int MS_CYCLES = (WINDOW_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_W = 27;
	localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);
	localparam logic [CNT_W-1:0] FREQ_MIN = 32'h1;
	localparam logic [CNT_W-1:0] FREQ_MAX16 = 32'h7fff;
	localparam logic [CNT_W-1:0] FREQ_MAX32 = 32'h186a0;
	typedef enum logic [2:0] {
		PG_IDLE = 3'b001,
		PG_RUN = 3'b010,
		PG_DONE = 3'b100
	} pgState_t;
endpackage : fast_counter_pkg

// file: pulse_gen_channel.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_channel (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic wideMode,
	input wire logic [fast_counter_pkg::CNT_W-1:0] freq,
	input wire logic [fast_counter_pkg::CNT_W-1:0] count,
	output logic pulseOut,
	output logic active,
	output logic done
);
	import fast_counter_pkg::*;
	pgState_t state_q;
	logic enPrev_q;
	logic [CNT_W-1:0] target_q;
	logic [CNT_W-1:0] emitted_q;
	logic [ACC_W-1:0] acc_q;
	logic [CNT_W-1:0] fClamp;
	logic [ACC_W-1:0] step;
	logic [ACC_W-1:0] accSum;
	logic toggle;
	logic start;
	logic lastPulse;

	// clamp frequency to the legal range of the chosen form
	always_comb begin
		fClamp = freq;
		if (freq < FREQ_MIN)
			fClamp = FREQ_MIN;
		else if (!wideMode && freq > FREQ_MAX16)
			fClamp = FREQ_MAX16;
		else if (wideMode && freq > FREQ_MAX32)
			fClamp = FREQ_MAX32;
	end

	// two toggles per period keep duty at one half
	assign step = ACC_W'({fClamp, 1'b0});
	assign accSum = acc_q + step;
	assign toggle = (state_q == PG_RUN) && (accSum >= ACC_WRAP);
	assign start = enable && !enPrev_q;
	assign lastPulse = (target_q != '0) && (emitted_q + 32'h1 == target_q);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			enPrev_q <= 1'b0;
		else
			enPrev_q <= enable;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= PG_IDLE;
			target_q <= '0;
			emitted_q <= '0;
			acc_q <= '0;
			pulseOut <= 1'b0;
		end else if (!enable) begin
			state_q <= PG_IDLE;
			pulseOut <= 1'b0;
		end else if (start) begin
			state_q <= PG_RUN;
			target_q <= count;
			emitted_q <= '0;
			acc_q <= '0;
			pulseOut <= 1'b0;
		end else if (state_q == PG_RUN) begin
			acc_q <= toggle ? accSum - ACC_WRAP : accSum;
			if (toggle) begin
				pulseOut <= !pulseOut;
				if (pulseOut) begin
					emitted_q <= emitted_q + 32'h1;
					if (lastPulse)
						state_q <= PG_DONE;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			active <= 1'b0;
		else if (!enable || state_q != PG_RUN || (toggle && pulseOut && lastPulse))
			active <= 1'b0;
		else if (toggle && !pulseOut)
			active <= 1'b1;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			done <= 1'b0;
		else if (start || !enable)
			done <= 1'b0;
		else if (toggle && pulseOut && lastPulse)
			done <= 1'b1;
	end

	disable_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!enable |=> !pulseOut) else $error("output high after disable");
	done_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		done |-> !active && !pulseOut) else $error("generator still active after done");
	endless_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state_q == PG_RUN && target_q == '0 && enable) |=> state_q == PG_RUN)
		else $error("endless run stopped");
endmodule : pulse_gen_channel
`default_nettype wire

// file: fast_counter_compare_pulse_unit.sv
`timescale 1ns/1ps
`default_nettype none
module fast_counter_compare_pulse_unit #(
	parameter int MS_CYCLES_P = fast_counter_pkg::MS_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [fast_counter_pkg::CNT_W-1:0] cntValue,
	input wire logic cntStep,
	input wire logic setEnable,
	input wire logic [fast_counter_pkg::CNT_W-1:0] setValue,
	input wire logic setToIrq,
	input wire logic [fast_counter_pkg::VEC_W-1:0] setIrqVector,
	input wire logic irqInhibit,
	input wire logic clrEnable,
	input wire logic [fast_counter_pkg::CNT_W-1:0] clrValue,
	input wire logic clrToCounter,
	input wire logic zoneEnable,
	input wire logic [fast_counter_pkg::CNT_W-1:0] zoneLow,
	input wire logic [fast_counter_pkg::CNT_W-1:0] zoneHigh,
	input wire logic densityIn,
	input wire logic densityEnable,
	input wire logic [fast_counter_pkg::WIN_W-1:0] densityWindowMs,
	input wire logic pgEnable0,
	input wire logic pgWide0,
	input wire logic [fast_counter_pkg::CNT_W-1:0] pgFreq0,
	input wire logic [fast_counter_pkg::CNT_W-1:0] pgCount0,
	input wire logic pgEnable1,
	input wire logic pgWide1,
	input wire logic [fast_counter_pkg::CNT_W-1:0] pgFreq1,
	input wire logic [fast_counter_pkg::CNT_W-1:0] pgCount1,
	output logic compareOut,
	output logic irqReq,
	output logic [fast_counter_pkg::VEC_W-1:0] irqVector,
	output logic cntClear,
	output logic [fast_counter_pkg::ZONE_N-1:0] zoneOut,
	output logic [fast_counter_pkg::CNT_W-1:0] densityResult,
	output logic [fast_counter_pkg::CNT_W-1:0] densityRunCount,
	output logic [fast_counter_pkg::WIN_W-1:0] densityRemainMs,
	output logic pulseOut0,
	output logic pulseOut1,
	output logic ch0Active,
	output logic ch1Active,
	output logic pulseDone
);
	import fast_counter_pkg::*;

	localparam logic [WIN_W-1:0] MS_LAST = WIN_W'(MS_CYCLES_P - 1);

	logic setMatch;
	logic clrMatch;
	logic vecLegal;
	logic zoneEnPrev_q;
	logic zoneStart;
	logic zoneEval;
	logic [ZONE_N-1:0] zoneNext;

	// comparisons see only values reached by a count step
	assign setMatch = cntStep && setEnable && (cntValue == setValue);
	assign clrMatch = cntStep && clrEnable && (cntValue == clrValue);
	assign vecLegal = (setIrqVector >= VEC_FIRST) && (setIrqVector <= VEC_LAST);

	// output contact: set match drives, clear match releases
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			compareOut <= 1'b0;
		else if (setMatch && !setToIrq)
			compareOut <= 1'b1;
		else if (clrMatch && !clrToCounter)
			compareOut <= 1'b0;
	end

	// interrupt request pulse carries the vector index
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqReq <= 1'b0;
			irqVector <= '0;
		end else begin
			irqReq <= setMatch && setToIrq && vecLegal && !irqInhibit;
			if (setMatch && setToIrq && vecLegal)
				irqVector <= setIrqVector;
		end
	end

	// counter self-reset leaves the contact untouched
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			cntClear <= 1'b0;
		else
			cntClear <= clrMatch && clrToCounter;
	end

	assign zoneStart = zoneEnable && !zoneEnPrev_q;
	assign zoneEval = zoneStart || (zoneEnable && cntStep);

	always_comb begin
		zoneNext = '0;
		if (cntValue < zoneLow)
			zoneNext[ZONE_BELOW] = 1'b1;
		else if (cntValue > zoneHigh)
			zoneNext[ZONE_ABOVE] = 1'b1;
		else
			zoneNext[ZONE_INSIDE] = 1'b1;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			zoneEnPrev_q <= 1'b0;
		else
			zoneEnPrev_q <= zoneEnable;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			zoneOut <= '0;
		else if (!zoneEnable)
			zoneOut <= '0;
		else if (zoneEval)
			zoneOut <= zoneNext;
	end

	// density input arrives from a field pin
	logic densSync1_q;
	logic densSync2_q;
	logic densPrev_q;
	logic densEdge;
	logic densEnPrev_q;
	logic densStart;
	logic [WIN_W-1:0] msDiv_q;
	logic msTick;
	logic [WIN_W-1:0] winLen;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			densSync1_q <= 1'b0;
			densSync2_q <= 1'b0;
			densPrev_q <= 1'b0;
		end else begin
			densSync1_q <= densityIn;
			densSync2_q <= densSync1_q;
			densPrev_q <= densSync2_q;
		end
	end

	assign densEdge = densSync2_q && !densPrev_q;
	assign densStart = densityEnable && !densEnPrev_q;
	assign winLen = (densityWindowMs == '0) ? 16'h0001 : densityWindowMs;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			densEnPrev_q <= 1'b0;
		else
			densEnPrev_q <= densityEnable;
	end

	// millisecond enable from a divider restarted with the meter
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			msDiv_q <= '0;
		else if (!densityEnable || densStart || msTick)
			msDiv_q <= '0;
		else
			msDiv_q <= msDiv_q + 16'h0001;
	end

	assign msTick = densityEnable && !densStart && (msDiv_q == MS_LAST);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			densityRunCount <= '0;
			densityRemainMs <= '0;
			densityResult <= '0;
		end else if (!densityEnable) begin
			densityRunCount <= '0;
			densityRemainMs <= '0;
		end else if (densStart) begin
			densityRunCount <= '0;
			densityRemainMs <= winLen;
		end else if (msTick && densityRemainMs <= 16'h0001) begin
			densityResult <= densityRunCount + {31'h0, densEdge};
			densityRunCount <= '0;
			densityRemainMs <= winLen;
		end else begin
			if (densEdge)
				densityRunCount <= densityRunCount + 32'h1;
			if (msTick)
				densityRemainMs <= densityRemainMs - 16'h0001;
		end
	end

	// two independent generators, one per dedicated output
	logic [1:0] pgEn;
	logic [1:0] pgWide;
	logic [CNT_W-1:0] pgFreq [2];
	logic [CNT_W-1:0] pgCount [2];
	logic [1:0] pgOut;
	logic [1:0] pgActive;
	logic [1:0] pgDone;

	assign pgEn = {pgEnable1, pgEnable0};
	assign pgWide = {pgWide1, pgWide0};
	assign pgFreq[0] = pgFreq0;
	assign pgFreq[1] = pgFreq1;
	assign pgCount[0] = pgCount0;
	assign pgCount[1] = pgCount1;

	for (genvar ch = 0; ch < 2; ch++) begin : gChannel
		pulse_gen_channel uGen (
			.sys_clk(sys_clk),
			.sys_rst(sys_rst),
			.enable(pgEn[ch]),
			.wideMode(pgWide[ch]),
			.freq(pgFreq[ch]),
			.count(pgCount[ch]),
			.pulseOut(pgOut[ch]),
			.active(pgActive[ch]),
			.done(pgDone[ch])
		);
	end

	assign pulseOut0 = pgOut[0];
	assign pulseOut1 = pgOut[1];
	assign ch0Active = pgActive[0];
	assign ch1Active = pgActive[1];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			pulseDone <= 1'b0;
		else
			pulseDone <= |pgDone;
	end

	// helper: length of the last channel-0 high phase and of the low phase after it
	logic [CNT_W-1:0] highLen_q;
	logic [CNT_W-1:0] lowLen_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			highLen_q <= '0;
			lowLen_q <= '0;
		end else if (!pgEnable0) begin
			highLen_q <= '0;
			lowLen_q <= '0;
		end else if (pgOut[0]) begin
			// a new high phase restarts its count; low count cleared
			highLen_q <= (lowLen_q != '0) ? 32'h1 : highLen_q + 32'h1;
			lowLen_q <= '0;
		end else begin
			// high count is kept through the low phase for the duty check
			lowLen_q <= lowLen_q + 32'h1;
		end
	end

	set_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(setMatch && !setToIrq) |=> compareOut) else $error("set match missed");
	no_step_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!cntStep |=> $stable(compareOut) && !irqReq && !cntClear)
		else $error("compare changed without count step");
	irq_inhibit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$past(irqInhibit) |-> !irqReq) else $error("interrupt while inhibited");
	irq_raise_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(setMatch && setToIrq && vecLegal && !irqInhibit) |=> irqReq && irqVector == $past(setIrqVector))
		else $error("interrupt request missing");
	clr_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clrMatch && !clrToCounter && !setMatch) |=> !compareOut)
		else $error("clear match missed");
	self_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clrMatch && clrToCounter && !(setMatch && !setToIrq))
		|=> cntClear && compareOut == $past(compareOut))
		else $error("counter reset wrong");
	irq_bad_vec_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(setMatch && setToIrq && !vecLegal) |=> !irqReq)
		else $error("interrupt on illegal vector");
	zone_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!zoneEnable |=> zoneOut == '0)
		else $error("zone outputs set while disabled");
	zone_onehot_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		zoneEnable && zoneEnPrev_q |-> $onehot(zoneOut)) else $error("zone outputs not one-hot");
	zone_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		zoneStart |=> zoneOut == $past(zoneNext)) else $error("zone not set on enable");
	dens_store_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(densityEnable && !densStart && msTick && densityRemainMs == 16'h0001)
		|=> densityRunCount == '0 && densityRemainMs == $past(winLen))
		else $error("density window not restarted");
	dens_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!densityEnable |=> densityRunCount == '0 && densityRemainMs == '0)
		else $error("density meter runs while disabled");
	done_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(|pgDone) |=> pulseDone)
		else $error("pulse done flag missing");
	half_duty_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(pgEnable0 && $rose(pgOut[0]) && highLen_q > 32'h1 && lowLen_q > 32'h1)
		|-> (highLen_q >= lowLen_q - 32'h1) && (highLen_q <= lowLen_q + 32'h1))
		else $error("duty not one half");
endmodule : fast_counter_compare_pulse_unit
`default_nettype wire

// file: fast_counter_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module fast_counter_field_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic stepReq,
	input wire logic stepDown,
	input wire logic loadReq,
	input wire logic [fast_counter_pkg::CNT_W-1:0] loadValue,
	input wire logic cntClear,
	output logic [fast_counter_pkg::CNT_W-1:0] cntValue,
	output logic cntStep
);
	import fast_counter_pkg::*;
	// a single fast counter feeds every compare
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cntValue <= '0;
			cntStep <= 1'b0;
		end else begin
			// program loads move the value without a step pulse
			cntStep <= stepReq;
			if (cntClear)
				cntValue <= '0;
			else if (loadReq)
				cntValue <= loadValue;
			else if (stepReq)
				cntValue <= stepDown ? cntValue - 32'h1 : cntValue + 32'h1;
		end
	end
endmodule : fast_counter_field_model
`default_nettype wire

// file: fast_counter_compare_pulse_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module fast_counter_compare_pulse_unit_test;
	import fast_counter_pkg::*;
	logic sys_clk, sys_rst;
	logic [CNT_W-1:0] cntValue, setValue, clrValue, zoneLow, zoneHigh, loadValue;
	logic [CNT_W-1:0] pgFreq0, pgCount0, pgFreq1, pgCount1, densityResult, densityRunCount;
	logic [VEC_W-1:0] setIrqVector, irqVector;
	logic [ZONE_N-1:0] zoneOut;
	logic [WIN_W-1:0] densityWindowMs, densityRemainMs;
	logic cntStep, setEnable, setToIrq, irqInhibit, clrEnable, clrToCounter, zoneEnable;
	logic densityIn, densityEnable, pgEnable0, pgWide0, pgEnable1, pgWide1;
	logic compareOut, irqReq, cntClear, pulseOut0, pulseOut1, ch0Active, ch1Active, pulseDone;
	logic stepReq, stepDown, loadReq;
	int fails, numChecks, n0, hi, lo;

	fast_counter_compare_pulse_unit #(.MS_CYCLES_P(10)) i_dut (.*);
	fast_counter_field_model i_far (.*);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	always @(posedge pulseOut0) n0++;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic chk_bit(input logic got, input logic exp, input string msg);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s got %b exp %b", $time, msg, got, exp);
		end
	endtask : chk_bit

	task automatic chk_word(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp,
		input string msg);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk_word

	task automatic timed_out();
		fails++;
		$display("MISMATCH t=%0t wait ran out", $time);
		finish_test();
	endtask : timed_out

	task automatic step(input logic dn);
		stepReq = 1'b1;
		stepDown = dn;
		tick(1);
		stepReq = 1'b0;
		tick(1);
	endtask : step

	task automatic load(input logic [CNT_W-1:0] v);
		loadReq = 1'b1;
		loadValue = v;
		tick(1);
		loadReq = 1'b0;
		tick(1);
	endtask : load

	task automatic zstep(input logic [CNT_W-1:0] v, input logic dn, input logic [2:0] exp);
		load(v);
		step(dn);
		chk_word(CNT_W'(zoneOut), CNT_W'(exp), "zone output");
	endtask : zstep

	function automatic logic pout(input logic ch);
		return ch ? pulseOut1 : pulseOut0;
	endfunction : pout

	// widths of the next whole high phase and the low phase after it, in cycles
	task automatic measure(input logic ch);
		int k;
		k = 0;
		hi = 0;
		lo = 0;
		while (pout(ch) !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
		while (pout(ch) === 1'b1 && k < 3000) begin
			tick(1);
			hi++;
			k++;
		end
		while (pout(ch) === 1'b0 && k < 3000) begin
			tick(1);
			lo++;
			k++;
		end
		if (k >= 3000)
			timed_out();
	endtask : measure

	task automatic wait_for(input logic idle, input int bound);
		int k;
		k = 0;
		while ((idle ? ch0Active !== 1'b0 : pulseDone !== 1'b1) && k < bound) begin
			tick(1);
			k++;
		end
		if (k >= bound)
			timed_out();
	endtask : wait_for

	initial begin
		{setValue, clrValue, zoneLow, zoneHigh, loadValue, pgFreq0, pgCount0} = '0;
		{pgFreq1, pgCount1, setIrqVector, densityWindowMs, setEnable, setToIrq} = '0;
		{irqInhibit, clrEnable, clrToCounter, zoneEnable, densityIn, densityEnable} = '0;
		{pgEnable0, pgWide0, pgEnable1, pgWide1, stepReq, stepDown, loadReq} = '0;
		{fails, numChecks, n0, hi, lo} = '0;
		sys_rst = 1'b1;
		tick(8);
		sys_rst = 1'b0;
		tick(1);
		// no more than three compares enabled at once
		setValue = 32'h5;
		setEnable = 1'b1;
		load(32'h5);
		chk_bit(compareOut, 1'b0, "load alone");
		load(32'h4);
		step(1'b0);
		chk_bit(compareOut, 1'b1, "set match");
		clrValue = 32'h3;
		clrEnable = 1'b1;
		step(1'b1);
		step(1'b1);
		chk_bit(compareOut, 1'b0, "clear match down");
		$display("test compare done");
		{clrEnable, setToIrq} = 2'b01;
		for (int v = 1; v <= 6; v++) begin
			setIrqVector = VEC_W'(v);
			load(32'h4);
			step(1'b0);
			chk_bit(irqReq, 1'b1, "irq pulse");
			chk_word(CNT_W'(irqVector), CNT_W'(v), "irq vector");
		end
		irqInhibit = 1'b1;
		load(32'h4);
		step(1'b0);
		chk_bit(irqReq, 1'b0, "irq inhibited");
		{setEnable, irqInhibit, clrEnable, clrToCounter} = 4'b0011;
		clrValue = 32'h7;
		load(32'h6);
		step(1'b0);
		chk_bit(cntClear, 1'b1, "counter reset");
		chk_bit(compareOut, 1'b0, "contact idle");
		clrEnable = 1'b0;
		tick(2);
		$display("test interrupt and reset done");
		zoneLow = 32'ha;
		zoneHigh = 32'h14;
		load(32'hf);
		zoneEnable = 1'b1;
		tick(2);
		chk_word(CNT_W'(zoneOut), 32'h2, "zone at enable");
		zstep(32'h8, 1'b0, 3'b001);
		zstep(32'h14, 1'b0, 3'b100);
		zstep(32'h15, 1'b1, 3'b010);
		zstep(32'hb, 1'b1, 3'b010);
		zstep(32'ha, 1'b1, 3'b001);
		zoneEnable = 1'b0;
		$display("test zone done");
		// the density pin feeds nothing else
		densityWindowMs = 16'h2;
		densityEnable = 1'b1;
		repeat (3) begin
			densityIn = 1'b1;
			tick(2);
			densityIn = 1'b0;
			tick(2);
		end
		tick(13);
		chk_word(densityResult, 32'h3, "density count");
		chk_word(CNT_W'(densityRemainMs), 32'h2, "window left");
		densityEnable = 1'b0;
		$display("test density done");
		// one generator per output
		pgFreq0 = 32'h186a0;
		pgCount0 = 32'h3;
		pgFreq1 = 32'h186a0;
		{pgWide0, pgEnable0, pgEnable1} = 3'b111;
		measure(1'b0);
		chk_bit(hi >= 199 && hi <= 201, 1'b1, "ch0 high");
		chk_bit(lo >= 199 && lo <= 201, 1'b1, "ch0 low");
		chk_bit(ch0Active, 1'b1, "ch0 running");
		pgCount0 = 32'ha;
		measure(1'b1);
		chk_bit(hi >= 609 && hi <= 612, 1'b1, "ch1 clamped");
		wait_for(1'b0, 3000);
		chk_word(CNT_W'(n0), 32'h3, "ch0 pulses");
		chk_bit(ch0Active, 1'b0, "ch0 finished");
		chk_bit(ch1Active, 1'b1, "ch1 endless");
		pgFreq1 = 32'h4e20;
		measure(1'b1);
		measure(1'b1);
		chk_bit(hi >= 999 && hi <= 1001, 1'b1, "ch1 new rate");
		pgEnable1 = 1'b0;
		tick(2);
		chk_bit(pulseOut1, 1'b0, "ch1 stopped");
		chk_bit(ch1Active, 1'b0, "ch1 idle");
		pgEnable0 = 1'b0;
		wait_for(1'b1, 100);
		tick(2);
		n0 = 0;
		pgCount0 = 32'h1;
		pgEnable0 = 1'b1;
		tick(3);
		wait_for(1'b0, 3000);
		chk_word(CNT_W'(n0), 32'h1, "restart count");
		$display("test pulse done");
		finish_test();
	end
endmodule : fast_counter_compare_pulse_unit_test
`default_nettype wire
